// File: design/bsb_cond.sv
// Branch condition table for the 2x opcode group.
module bsb_cond (
  input  wire logic [7:0] op_i,
  input  wire logic [7:0] ccr_i,
  output logic            take_o
);

  logic c;
  logic v;
  logic z;
  logic n;
  logic base;

  assign c = ccr_i[bsb_pkg::CCR_C];
  assign v = ccr_i[bsb_pkg::CCR_V];
  assign z = ccr_i[bsb_pkg::CCR_Z];
  assign n = ccr_i[bsb_pkg::CCR_N];

  // The even opcode of each pair holds the listed test; bit 0 inverts it.
  always_comb begin
    unique case (op_i[3:1])
      3'h0: base = 1'b1;
      3'h1: base = ~(c | z);
      3'h2: base = ~c;
      3'h3: base = ~z;
      3'h4: base = ~v;
      3'h5: base = ~n;
      3'h6: base = ~(n ^ v);
      3'h7: base = ~(z | (n ^ v));
    endcase
  end

  assign take_o = base ^ op_i[0];

endmodule // bsb_cond

// File: design/bsb_core.sv
// Execution core for bit-set, branch-to-subroutine and conditional branches.
// ----------------------------------------------------------------
// Function
// - A bit-set sets N from result bit 7, Z when the result is zero and clears V.
// - Bit-set decodes from 14, 1C and 18 1C and takes 6, 7 and 8 bus cycles.
// - Branch-to-subroutine first advances the program counter by two to the return address.
// - The low return byte is written at the stack pointer, which then drops by one.
// - The high return byte is written at the new stack pointer, which drops by one again.
// - After both pushes the program counter loads the return address plus the offset.
// - Branch-to-subroutine is opcode 8D with fetch, offset, idle, target read and two pushes.
// - Branch-to-subroutine takes a relative offset and changes no condition flag.
// - Opcode 28 branches only when V is clear and changes no flag.
// - Conditional branches take fetch, offset fetch and an idle read at FFFF.
// - Branch conditions follow the paired table, with bit 0 selecting the complement.
// ----------------------------------------------------------------
//
// Chosen here: the register addresses and the Wishbone slave port.
module bsb_core #(
  parameter int unsigned BUS_DIV = bsb_pkg::BUS_DIV_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [15:0] mem_addr_o,
  input  wire logic [7:0]  mem_data_i,
  output logic      [7:0]  mem_data_o,
  output logic             mem_data_oe_n_o,
  output logic             mem_read_o,
  output logic             mem_cycle_end_o
);

  // ----------------------------------------------------------------
  // Bus cycle divider
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_LAST = 8'(BUS_DIV - 1);

  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic       bus_en;
  logic       end_reg;

  assign bus_en   = (div_reg == DIV_LAST);
  assign div_next = bus_en ? 8'h00 : 8'(div_reg + 8'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 8'h00;
      end_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      end_reg <= (div_next == DIV_LAST);
    end
  end

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  bsb_pkg::bsb_state_t st_reg;
  bsb_pkg::bsb_state_t st_next;
  logic [15:0] pc_reg,   pc_next;
  logic [15:0] sp_reg,   sp_next;
  logic [15:0] x_reg;
  logic [15:0] y_reg;
  logic [15:0] ea_reg,   ea_next;
  logic [7:0]  ccr_reg,  ccr_next;
  logic [7:0]  op_reg,   op_next;
  logic [7:0]  opr_reg,  opr_next;
  logic [7:0]  mem_reg,  mem_next;
  logic [7:0]  mask_reg, mask_next;
  logic        yb_reg,   yb_next;
  logic [15:0] addr_reg;
  logic [7:0]  dout_reg;
  logic        rd_reg;
  logic        run_reg;
  logic        ill_reg;
  logic        ill_set;

  logic [15:0] off_ext;
  logic [15:0] br_tgt;
  logic [15:0] ea_idx;
  logic        take;
  logic        run_ok;
  logic        halt;
  logic        known_op;
  logic        is_br;

  assign off_ext  = {{8{opr_reg[7]}}, opr_reg};
  assign br_tgt   = 16'(pc_reg + off_ext);
  assign ea_idx   = 16'((yb_reg ? y_reg : x_reg) + {8'h00, opr_reg});
  assign run_ok   = run_reg & ~ill_reg;
  assign halt     = ~run_ok & (st_reg == bsb_pkg::ST_FETCH);
  assign is_br    = (op_reg[7:4] == bsb_pkg::OP_BR_GROUP);
  assign known_op = (mem_data_i == bsb_pkg::OP_SETB_DIR) | (mem_data_i == bsb_pkg::OP_SUBR)
                  | (mem_data_i == bsb_pkg::OP_SETB_IDX)
                  | (mem_data_i[7:4] == bsb_pkg::OP_BR_GROUP);

  bsb_cond u_cond (
    .op_i   (op_reg),
    .ccr_i  (ccr_reg),
    .take_o (take)
  );

  function automatic logic [15:0] bus_addr(input bsb_pkg::bsb_state_t s,
                                           input logic [15:0] pc, input logic [15:0] ea,
                                           input logic [15:0] sp, input logic [15:0] tgt);
    unique case (s)
      bsb_pkg::ST_IDLE_X, bsb_pkg::ST_IDLE_M, bsb_pkg::ST_IDLE_BR: bus_addr = bsb_pkg::IDLE_ADDR;
      bsb_pkg::ST_READ_M, bsb_pkg::ST_WRITE_M: bus_addr = ea;
      bsb_pkg::ST_SUB_RD: bus_addr = tgt;
      bsb_pkg::ST_PUSH_LO, bsb_pkg::ST_PUSH_HI: bus_addr = sp;
      default: bus_addr = pc;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_next   = st_reg;
    pc_next   = pc_reg;
    sp_next   = sp_reg;
    ea_next   = ea_reg;
    ccr_next  = ccr_reg;
    op_next   = op_reg;
    opr_next  = opr_reg;
    mem_next  = mem_reg;
    mask_next = mask_reg;
    yb_next   = yb_reg;
    ill_set   = 1'b0;
    unique case (st_reg)
      bsb_pkg::ST_FETCH: begin
        if (run_ok) begin
          op_next = mem_data_i;
          pc_next = 16'(pc_reg + 16'h0001);
          yb_next = 1'b0;
          if (mem_data_i == bsb_pkg::OP_PREFIX_Y) begin
            st_next = bsb_pkg::ST_PRE;
          end else if (known_op) begin
            st_next = bsb_pkg::ST_OPER;
          end else begin
            ill_set = 1'b1;
          end
        end
      end
      bsb_pkg::ST_PRE: begin
        op_next = mem_data_i;
        pc_next = 16'(pc_reg + 16'h0001);
        yb_next = 1'b1;
        if (mem_data_i == bsb_pkg::OP_SETB_IDX) begin
          st_next = bsb_pkg::ST_OPER;
        end else begin
          ill_set = 1'b1;
          st_next = bsb_pkg::ST_FETCH;
        end
      end
      bsb_pkg::ST_OPER: begin
        opr_next = mem_data_i;
        pc_next  = 16'(pc_reg + 16'h0001);
        if (op_reg == bsb_pkg::OP_SETB_DIR) begin
          ea_next = {8'h00, mem_data_i};
          st_next = bsb_pkg::ST_READ_M;
        end else if (op_reg == bsb_pkg::OP_SETB_IDX) begin
          st_next = bsb_pkg::ST_IDLE_X;
        end else begin
          st_next = bsb_pkg::ST_IDLE_BR;
        end
      end
      bsb_pkg::ST_IDLE_X: begin
        ea_next = ea_idx;
        st_next = bsb_pkg::ST_READ_M;
      end
      bsb_pkg::ST_READ_M: begin
        mem_next = mem_data_i;
        st_next  = bsb_pkg::ST_MASK;
      end
      bsb_pkg::ST_MASK: begin
        mask_next = mem_data_i;
        pc_next   = 16'(pc_reg + 16'h0001);
        st_next   = bsb_pkg::ST_IDLE_M;
      end
      bsb_pkg::ST_IDLE_M: st_next = bsb_pkg::ST_WRITE_M;
      bsb_pkg::ST_WRITE_M: begin
        ccr_next[bsb_pkg::CCR_N] = dout_reg[7];
        ccr_next[bsb_pkg::CCR_Z] = (dout_reg == 8'h00);
        ccr_next[bsb_pkg::CCR_V] = 1'b0;
        st_next = bsb_pkg::ST_FETCH;
      end
      bsb_pkg::ST_IDLE_BR: begin
        if (op_reg == bsb_pkg::OP_SUBR) begin
          st_next = bsb_pkg::ST_SUB_RD;
        end else begin
          if (take) begin
            pc_next = br_tgt;
          end
          st_next = bsb_pkg::ST_FETCH;
        end
      end
      bsb_pkg::ST_SUB_RD: st_next = bsb_pkg::ST_PUSH_LO;
      bsb_pkg::ST_PUSH_LO: begin
        sp_next = 16'(sp_reg - 16'h0001);
        st_next = bsb_pkg::ST_PUSH_HI;
      end
      bsb_pkg::ST_PUSH_HI: begin
        sp_next = 16'(sp_reg - 16'h0001);
        pc_next = br_tgt;
        st_next = bsb_pkg::ST_FETCH;
      end
      default: st_next = bsb_pkg::ST_FETCH;
    endcase
  end

  // The value to drive is chosen for the state being entered, so every pin is a flop.
  logic [15:0] addr_next;
  logic        rd_next;
  logic [7:0]  dout_next;

  assign addr_next = bus_addr(st_next, pc_next, ea_next, sp_next, br_tgt);
  assign rd_next   = ~((st_next == bsb_pkg::ST_WRITE_M) | (st_next == bsb_pkg::ST_PUSH_LO)
                     | (st_next == bsb_pkg::ST_PUSH_HI));
  assign dout_next = (st_next == bsb_pkg::ST_WRITE_M) ? (mem_reg | mask_reg) :
                     (st_next == bsb_pkg::ST_PUSH_LO) ? pc_next[7:0] :
                     (st_next == bsb_pkg::ST_PUSH_HI) ? pc_next[15:8] : 8'h00;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] rd_mux;
  logic [31:0] pc_w;
  logic [31:0] sp_w;
  logic [31:0] x_w;
  logic [31:0] y_w;
  logic [31:0] ccr_w;
  logic        ill_clr;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  assign wb_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wb_wr   = wb_req & wb_we_i;
  assign pc_w    = merge({16'h0000, pc_reg}, wb_dat_i, wb_sel_i);
  assign sp_w    = merge({16'h0000, sp_reg}, wb_dat_i, wb_sel_i);
  assign x_w     = merge({16'h0000, x_reg}, wb_dat_i, wb_sel_i);
  assign y_w     = merge({16'h0000, y_reg}, wb_dat_i, wb_sel_i);
  assign ccr_w   = merge({24'h000000, ccr_reg}, wb_dat_i, wb_sel_i);
  assign ill_clr = wb_wr & (wb_adr_i == bsb_pkg::ADR_STAT) & wb_sel_i[0] & wb_dat_i[0];
  assign rd_mux  = (wb_adr_i == bsb_pkg::ADR_CTRL) ? {31'h00000000, run_reg} :
                   (wb_adr_i == bsb_pkg::ADR_PC)   ? {16'h0000, pc_reg} :
                   (wb_adr_i == bsb_pkg::ADR_SP)   ? {16'h0000, sp_reg} :
                   (wb_adr_i == bsb_pkg::ADR_X)    ? {16'h0000, x_reg} :
                   (wb_adr_i == bsb_pkg::ADR_Y)    ? {16'h0000, y_reg} :
                   (wb_adr_i == bsb_pkg::ADR_CCR)  ? {24'h000000, ccr_reg} :
                   (wb_adr_i == bsb_pkg::ADR_STAT) ?
                     {16'h0000, op_reg, 6'h00, ~halt, ill_reg} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h00000000;
      run_reg  <= 1'b0;
    end else begin
      ack_reg  <= wb_req;
      rdat_reg <= wb_req ? rd_mux : rdat_reg;
      if (wb_wr && wb_adr_i == bsb_pkg::ADR_CTRL && wb_sel_i[0]) begin
        run_reg <= wb_dat_i[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Core registers; software may load them only while the core is halted.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg   <= bsb_pkg::ST_FETCH;
      pc_reg   <= bsb_pkg::PC_RST;
      sp_reg   <= bsb_pkg::SP_RST;
      x_reg    <= bsb_pkg::IDX_RST;
      y_reg    <= bsb_pkg::IDX_RST;
      ea_reg   <= 16'h0000;
      ccr_reg  <= bsb_pkg::CCR_RST;
      op_reg   <= 8'h00;
      opr_reg  <= 8'h00;
      mem_reg  <= 8'h00;
      mask_reg <= 8'h00;
      yb_reg   <= 1'b0;
      addr_reg <= bsb_pkg::PC_RST;
      dout_reg <= 8'h00;
      rd_reg   <= 1'b1;
    end else begin
      if (bus_en) begin
        st_reg   <= st_next;
        pc_reg   <= pc_next;
        sp_reg   <= sp_next;
        ea_reg   <= ea_next;
        ccr_reg  <= ccr_next;
        op_reg   <= op_next;
        opr_reg  <= opr_next;
        mem_reg  <= mem_next;
        mask_reg <= mask_next;
        yb_reg   <= yb_next;
        addr_reg <= addr_next;
        dout_reg <= dout_next;
        rd_reg   <= rd_next;
      end
      if (wb_wr && halt) begin
        if (wb_adr_i == bsb_pkg::ADR_PC)  pc_reg  <= pc_w[15:0];
        if (wb_adr_i == bsb_pkg::ADR_SP)  sp_reg  <= sp_w[15:0];
        if (wb_adr_i == bsb_pkg::ADR_X)   x_reg   <= x_w[15:0];
        if (wb_adr_i == bsb_pkg::ADR_Y)   y_reg   <= y_w[15:0];
        if (wb_adr_i == bsb_pkg::ADR_CCR) ccr_reg <= ccr_w[7:0];
      end
    end
  end

  // A new illegal opcode wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ill_reg <= 1'b0;
    end else begin
      ill_reg <= (bus_en & ill_set) | (ill_reg & ~ill_clr);
    end
  end

  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = rdat_reg;
  assign mem_addr_o      = addr_reg;
  assign mem_data_o      = dout_reg;
  assign mem_read_o      = rd_reg;
  assign mem_data_oe_n_o = rd_reg;
  assign mem_cycle_end_o = end_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0]  cnt_reg;
  logic [15:0] opa_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 4'h0;
      opa_reg <= 16'h0000;
    end else if (bus_en) begin
      cnt_reg <= (st_reg == bsb_pkg::ST_FETCH) ? 4'h1 : 4'(cnt_reg + 4'h1);
      opa_reg <= (st_reg == bsb_pkg::ST_FETCH) ? pc_reg : opa_reg;
    end
  end

  property p_setb_flags;
    @(posedge clk_i) disable iff (rst_i)
    (bus_en && st_reg == bsb_pkg::ST_WRITE_M) |=> ccr_reg[bsb_pkg::CCR_N] == $past(dout_reg[7])
      && ccr_reg[bsb_pkg::CCR_Z] == ($past(dout_reg) == 8'h00) && !ccr_reg[bsb_pkg::CCR_V];
  endproperty
  a_setb_flags: assert property (p_setb_flags) else $error("bit-set flags wrong");

  property p_setb_len;
    @(posedge clk_i) disable iff (rst_i)
    (bus_en && st_reg == bsb_pkg::ST_WRITE_M) |-> cnt_reg + 4'h1 == (yb_reg ?
      bsb_pkg::CYC_SETB_Y : (op_reg == bsb_pkg::OP_SETB_DIR) ?
      bsb_pkg::CYC_SETB_DIR : bsb_pkg::CYC_SETB_X);
  endproperty
  a_setb_len: assert property (p_setb_len) else $error("bit-set length wrong");

  property p_setb_write;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg == bsb_pkg::ST_WRITE_M) |-> !mem_read_o && mem_addr_o == ea_reg
      && mem_data_o == (mem_reg | mask_reg) && !mem_data_oe_n_o;
  endproperty
  a_setb_write: assert property (p_setb_write) else $error("bit-set write wrong");

  property p_idle;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg inside {bsb_pkg::ST_IDLE_X, bsb_pkg::ST_IDLE_M, bsb_pkg::ST_IDLE_BR})
      |-> mem_addr_o == bsb_pkg::IDLE_ADDR && mem_read_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle not at FFFF");

  property p_push_lo;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg == bsb_pkg::ST_PUSH_LO) |-> mem_addr_o == sp_reg && !mem_read_o
      && mem_data_o == pc_reg[7:0] && pc_reg == 16'(opa_reg + 16'h0002);
  endproperty
  a_push_lo: assert property (p_push_lo) else $error("low return push wrong");

  property p_push_hi;
    @(posedge clk_i) disable iff (rst_i)
    (bus_en && st_reg == bsb_pkg::ST_PUSH_LO) |=> st_reg == bsb_pkg::ST_PUSH_HI
      && sp_reg == 16'($past(sp_reg) - 16'h0001) && mem_addr_o == sp_reg
      && mem_data_o == pc_reg[15:8];
  endproperty
  a_push_hi: assert property (p_push_hi) else $error("high return push wrong");

  property p_subr_end;
    @(posedge clk_i) disable iff (rst_i)
    (bus_en && st_reg == bsb_pkg::ST_PUSH_HI) |-> cnt_reg + 4'h1 == bsb_pkg::CYC_SUBR
      ##1 pc_reg == $past(br_tgt) && sp_reg == 16'($past(sp_reg) - 16'h0001)
      && ccr_reg == $past(ccr_reg);
  endproperty
  a_subr_end: assert property (p_subr_end) else $error("call entry wrong");

  property p_no_ovf;
    @(posedge clk_i) disable iff (rst_i)
    (bus_en && st_reg == bsb_pkg::ST_IDLE_BR && op_reg == bsb_pkg::OP_NO_OVF) |=>
      pc_reg == ($past(ccr_reg[bsb_pkg::CCR_V]) ? $past(pc_reg) : $past(br_tgt))
      && ccr_reg == $past(ccr_reg);
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("no-overflow branch wrong");

  property p_br_len;
    @(posedge clk_i) disable iff (rst_i)
    (bus_en && st_reg == bsb_pkg::ST_IDLE_BR && is_br) |-> cnt_reg + 4'h1 == bsb_pkg::CYC_BRANCH;
  endproperty
  a_br_len: assert property (p_br_len) else $error("branch length wrong");

  property p_cond;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg == bsb_pkg::ST_IDLE_BR) |->
      (op_reg != bsb_pkg::OP_SGT || take == !(ccr_reg[bsb_pkg::CCR_Z]
        | (ccr_reg[bsb_pkg::CCR_N] ^ ccr_reg[bsb_pkg::CCR_V])))
      && (op_reg != bsb_pkg::OP_UGT
        || take == !(ccr_reg[bsb_pkg::CCR_C] | ccr_reg[bsb_pkg::CCR_Z]))
      && (op_reg != bsb_pkg::OP_ALWAYS || take) && (op_reg != 8'h21 || !take);
  endproperty
  a_cond: assert property (p_cond) else $error("branch condition wrong");

  property p_sext;
    @(posedge clk_i) disable iff (rst_i)
    (bus_en && st_reg == bsb_pkg::ST_IDLE_BR && op_reg == bsb_pkg::OP_ALWAYS) |=>
      pc_reg == 16'($past(pc_reg) + {{8{$past(opr_reg[7])}}, $past(opr_reg)});
  endproperty
  a_sext: assert property (p_sext) else $error("offset not sign-extended");

endmodule // bsb_core

// File: design/bsb_pkg.sv
// Package with opcodes, register map, reset values and cycle counts of the core.
package bsb_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PREFIX_Y   = 8'h18;
  localparam logic [7:0] OP_SETB_DIR   = 8'h14;
  localparam logic [7:0] OP_SETB_IDX   = 8'h1C;
  localparam logic [7:0] OP_SUBR       = 8'h8D;
  localparam logic [7:0] OP_NO_OVF     = 8'h28;
  localparam logic [7:0] OP_ALWAYS     = 8'h20;
  localparam logic [7:0] OP_SGT        = 8'h2E;
  localparam logic [7:0] OP_UGT        = 8'h22;
  localparam logic [3:0] OP_BR_GROUP   = 4'h2;

  // ----------------------------------------------------------------
  // Bus constants and condition code bit positions
  // ----------------------------------------------------------------
  localparam logic [15:0] IDLE_ADDR    = 16'hFFFF;
  localparam int          CCR_C        = 0;
  localparam int          CCR_V        = 1;
  localparam int          CCR_Z        = 2;
  localparam int          CCR_N        = 3;

  // ----------------------------------------------------------------
  // Bus cycles per instruction and clocks per bus cycle
  // ----------------------------------------------------------------
  localparam logic [3:0]  CYC_SETB_DIR = 4'h6;
  localparam logic [3:0]  CYC_SETB_X   = 4'h7;
  localparam logic [3:0]  CYC_SETB_Y   = 4'h8;
  localparam logic [3:0]  CYC_SUBR     = 4'h6;
  localparam logic [3:0]  CYC_BRANCH   = 4'h3;
  localparam int unsigned BUS_DIV_DEF  = 4;

  // ----------------------------------------------------------------
  // Register byte offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_PC       = 8'h04;
  localparam logic [7:0]  ADR_SP       = 8'h08;
  localparam logic [7:0]  ADR_X        = 8'h0C;
  localparam logic [7:0]  ADR_Y        = 8'h10;
  localparam logic [7:0]  ADR_CCR      = 8'h14;
  localparam logic [7:0]  ADR_STAT     = 8'h18;
  localparam logic [15:0] PC_RST       = 16'h0000;
  localparam logic [15:0] SP_RST       = 16'h00FF;
  localparam logic [15:0] IDX_RST      = 16'h0000;
  localparam logic [7:0]  CCR_RST      = 8'h00;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_FETCH, ST_PRE, ST_OPER, ST_IDLE_X, ST_READ_M, ST_MASK,
    ST_IDLE_M, ST_WRITE_M, ST_IDLE_BR, ST_SUB_RD, ST_PUSH_LO, ST_PUSH_HI
  } bsb_state_t;

endpackage

// File: verif/bsb_mem_model.sv
// Memory model on the processor bus, with a log of bus cycles.
module bsb_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdat_i,
  input  wire logic        oe_n_i,
  input  wire logic        read_i,
  input  wire logic        end_i,
  output logic      [7:0]  rdat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [65536];
  logic [16:0] log_q [1024];
  int          n_log;
  // The wire carries the core's byte whenever it drives, so reads never see a stale value.
  assign rdat_o = oe_n_i ? mem[addr_i] : wdat_i;
  initial begin
    n_log = 0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge clk_i) begin
    if (!rst_i && end_i) begin
      if (!read_i) mem[addr_i] <= wdat_i;
      // The enable must follow the direction; a disagreement logs an unknown level.
      if (n_log < 1024) log_q[n_log] <= {(read_i === oe_n_i) ? read_i : 1'bx, addr_i};
      n_log <= n_log + 1;
    end
  end
endmodule // bsb_mem_model

// File: verif/test_bitset_subroutine_branch_exec.sv
// Self-checking bench for the bit-set, subroutine and branch core.
module test_bitset_subroutine_branch_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
  logic [3:0]  sel = 4'h0;
  logic        wb_ack_o, oe_n, rd, cend;
  logic [15:0] maddr;
  logic [7:0]  mdo, mdi;
  int          bad_count = 0, checks = 0, k, p, j;
  logic [7:0]  prog [16] = '{8'h14, 8'h40, 8'h81, 8'h1C, 8'h05, 8'hF0, 8'h18, 8'h1C,
                             8'h02, 8'h00, 8'h28, 8'h02, 8'h00, 8'h00, 8'h8D, 8'h10};
  logic [7:0]  ccv [4] = '{8'h00, 8'h02, 8'h0D, 8'h08};
  // Expected bus trace; bit 16 is the read level, so writes show as 0xxxx.
  logic [16:0] trace [31] = '{17'h10100, 17'h10101, 17'h10040, 17'h10102, 17'h1FFFF,
    17'h00040, 17'h10103, 17'h10104, 17'h1FFFF, 17'h10055, 17'h10105, 17'h1FFFF,
    17'h00055, 17'h10106, 17'h10107, 17'h10108, 17'h1FFFF, 17'h10062, 17'h10109,
    17'h1FFFF, 17'h00062, 17'h1010A, 17'h1010B, 17'h1FFFF, 17'h1010E, 17'h1010F,
    17'h1FFFF, 17'h10120, 17'h000FF, 17'h000FE, 17'h10120};

  always #2 clk_i = ~clk_i;

  bsb_core #(.BUS_DIV(1)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(maddr), .mem_data_i(mdi),
    .mem_data_o(mdo), .mem_data_oe_n_o(oe_n), .mem_read_o(rd), .mem_cycle_end_o(cend));
  bsb_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(maddr), .wdat_i(mdo),
    .oe_n_i(oe_n), .read_i(rd), .end_i(cend), .rdat_o(mdi));

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; ack is read in the active region, i.e. its value at the edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      conclude();
    end
    rdat = wb_dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask

  task automatic run(input logic [15:0] pc, input logic [7:0] cc);
    int n;
    wb(1'b1, bsb_pkg::ADR_CTRL, 32'h0);
    wb(1'b1, bsb_pkg::ADR_STAT, 32'h1);
    wb(1'b1, bsb_pkg::ADR_PC, {16'h0, pc});
    wb(1'b1, bsb_pkg::ADR_CCR, {24'h0, cc});
    wb(1'b1, bsb_pkg::ADR_CTRL, 32'h1);
    n = 0;
    do begin
      wb(1'b0, bsb_pkg::ADR_STAT, 32'h0);
      n++;
    end while (rdat[0] !== 1'b1 && n < 100);
    if (rdat[0] !== 1'b1) begin
      bad_count++;
      conclude();
    end
  endtask

  function automatic logic taken(input logic [7:0] op, input logic [7:0] c);
    logic n, z, v, cy, b;
    {n, z, v, cy} = c[3:0];
    case (op[3:1])
      3'h0: b = 1'b1;
      3'h1: b = !(cy | z);
      3'h2: b = !cy;
      3'h3: b = !z;
      3'h4: b = !v;
      3'h5: b = !n;
      3'h6: b = !(n ^ v);
      default: b = !(z | (n ^ v));
    endcase
    return b ^ op[0];
  endfunction

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, bsb_pkg::ADR_SP, 32'h0);
    chk("sp reset", 32'h00FF, rdat);
    wb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, rdat);
    $display("reset test done");
    for (k = 0; k < 16; k++) mem_u.mem[16'h0100 + k] = prog[k];
    mem_u.mem[16'h0040] = 8'h02;
    mem_u.mem[16'h0055] = 8'h0F;
    wb(1'b1, bsb_pkg::ADR_X, 32'h0050);
    wb(1'b1, bsb_pkg::ADR_Y, 32'h0060);
    run(16'h0100, 8'h03);
    k = 0;
    while (k < 1023 && mem_u.log_q[k] !== 17'h10101) k++;
    for (p = 0; p < 31; p++) begin
      chk("bus cycle", trace[p], mem_u.log_q[k - 1 + p]);
    end
    chk("mem 0040", 32'h83, mem_u.mem[16'h0040]);
    chk("mem 0055", 32'hFF, mem_u.mem[16'h0055]);
    chk("mem 00FF", 32'h10, mem_u.mem[16'h00FF]);
    chk("mem 00FE", 32'h01, mem_u.mem[16'h00FE]);
    wb(1'b0, bsb_pkg::ADR_SP, 32'h0);
    chk("sp", 32'h00FD, rdat);
    wb(1'b0, bsb_pkg::ADR_PC, 32'h0);
    chk("pc", 32'h0121, rdat);
    wb(1'b0, bsb_pkg::ADR_CCR, 32'h0);
    chk("ccr", 32'h05, rdat);
    $display("program test done");
    for (j = 0; j < 4; j++) begin
      for (k = 16'h0380; k < 16'h0500; k++) mem_u.mem[k] = 8'h00;
      p = 16'h0400;
      for (k = 0; k < 16; k++) begin
        mem_u.mem[p] = 8'h20 + k[7:0];
        mem_u.mem[p + 1] = taken(8'h20 + k[7:0], ccv[j]) ? 8'h02 : 8'h80;
        p = p + (taken(8'h20 + k[7:0], ccv[j]) ? 4 : 2);
      end
      // A backward jump to a halt byte below the chain proves the sign extension.
      mem_u.mem[p] = 8'h20;
      mem_u.mem[p + 1] = 8'hEE - p[7:0];
      run(16'h0400, ccv[j]);
      wb(1'b0, bsb_pkg::ADR_PC, 32'h0);
      chk("branch pc", 32'h03F1, rdat);
      wb(1'b0, bsb_pkg::ADR_CCR, 32'h0);
      chk("branch ccr", {24'h0, ccv[j]}, rdat);
    end
    $display("branch test done");
    conclude();
  end
endmodule // test_bitset_subroutine_branch_exec
